//--- rtl/srp_pkg.sv
// Constants and types shared by both ends of the serial ROM read port
`default_nettype none
package srp_pkg;
    // Instruction codes
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_QUICK = 8'h0b;
    // Last bit index of each field, and header lengths in serial bits
    localparam logic [4:0] CMD_LAST = 5'h07;
    localparam logic [4:0] ADDR_LAST = 5'h17;
    localparam logic [4:0] DUMMY_LAST = 5'h07;
    localparam int HDR_READ_BITS = 32;
    localparam int HDR_QUICK_BITS = 40;
    // Byte address width inside the array
    localparam int MEM_ADDR_W = 23;
    // Synchroniser reset: pause_n high, select_n low, so a select
    // held low across reset never looks like a falling edge
    localparam logic [3:0] SYNC_RST = 4'h8;
    // Timing of the master's own serial clock
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCLK_HALF_NS = 32;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Sequencer states
    typedef enum logic [2:0] {
        SD_IDLE, SD_CMD, SD_ADDR, SD_DUMMY, SD_DATA, SD_IGNORE
    } srp_dev_state_type;
    typedef enum logic [1:0] {
        SH_IDLE, SH_RUN, SH_PAUSE
    } srp_host_state_type;
endpackage
`default_nettype wire

//--- rtl/srp_if.sv
// Serial link between the master and the ROM read port
`default_nettype none
interface srp_if;
    logic sclk;      // Serial clock from master
    logic mosi;      // Master to device data
    logic miso;      // Device to master data
    logic miso_oe;   // Device drives miso while high
    logic select_n;  // Active low select
    logic pause_n;   // Active low pause
    modport dev (
        input sclk, mosi, select_n, pause_n,
        output miso, miso_oe
    );
    modport host (
        output sclk, mosi, select_n, pause_n,
        input miso, miso_oe
    );
endinterface
`default_nettype wire

//--- rtl/srp_device.sv
// Device end: serial ROM read port slave
`default_nettype none
module srp_device
    import srp_pkg::*;
#(
    parameter int ADDR_W = MEM_ADDR_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Serial link
    srp_if.dev bus,
    // Memory read port
    output logic mem_rd_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    input wire logic [7:0] mem_data_i,
    // Status
    output logic active_o,
    output logic paused_o
);

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [3:0] raw;  // Pins as they arrive
    logic [3:0] s1;   // First stage, read by s2 only
    logic [3:0] s2;   // Safe level
    logic [3:0] s3;   // Previous level, for edges

    assign raw = {bus.pause_n, bus.select_n, bus.mosi, bus.sclk};

    // Two flops per pin, plus a delay stage
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    s1[gi] <= SYNC_RST[gi];
                    s2[gi] <= SYNC_RST[gi];
                    s3[gi] <= SYNC_RST[gi];
                end else begin
                    s1[gi] <= raw[gi];
                    s2[gi] <= s1[gi];
                    s3[gi] <= s2[gi];
                end
            end
        end
    endgenerate

    logic sclk;       // Synced serial clock
    logic mosi;       // Synced serial input
    logic sel_n;      // Synced select
    logic pause_n;    // Synced pause
    logic sclk_rise;  // Clock rising edge seen
    logic sclk_fall;  // Clock falling edge seen
    logic sel_fall;   // Select asserted edge

    // Input data travels with the clock, so both stay aligned
    assign sclk = s2[0];
    assign mosi = s2[1];
    assign sel_n = s2[2];
    assign pause_n = s2[3];
    assign sclk_rise = s2[0] & ~s3[0];
    assign sclk_fall = ~s2[0] & s3[0];
    assign sel_fall = ~s2[2] & s3[2];

    ////////////////////////////////////////////////////////////////
    // Pause tracking

    logic paused;  // Pause condition in force

    // Level follows pause_n only while clock is low; deselect clears it at once
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            paused <= 1'b0;
        end else if (sel_n) begin
            paused <= 1'b0;
        end else if (!sclk) begin
            paused <= ~pause_n;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Instruction, address and dummy sequencer

    srp_dev_state_type state;  // Sequence position
    logic [4:0] cnt;           // Bits taken in field
    logic [23:0] in_sh;        // Input shifter
    logic quick;               // Dummy byte expected
    logic [23:0] next_in;      // Shifter with new bit
    logic addr_done;           // Last address bit taken
    logic [ADDR_W-1:0] start_addr;  // First byte address

    assign next_in = {in_sh[22:0], mosi};
    assign addr_done = (state == SD_ADDR) && sclk_rise && !paused && (cnt == ADDR_LAST);
    assign start_addr = next_in[ADDR_W-1:0];

    // Clock edges are ignored while paused; position is kept
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || sel_n) begin
            state <= SD_IDLE;
            cnt <= 5'h00;
            in_sh <= 24'h000000;
            quick <= 1'b0;
        end else if (sel_fall) begin
            state <= SD_CMD;
            cnt <= 5'h00;
        end else if (sclk_rise && !paused) begin
            in_sh <= next_in;
            cnt <= cnt + 5'h01;
            unique case (state)
                SD_IDLE: begin
                    cnt <= 5'h00;  // Held after reset while selected
                end
                SD_CMD: begin
                    if (cnt == CMD_LAST) begin
                        cnt <= 5'h00;
                        if (next_in[7:0] == CMD_READ) begin
                            state <= SD_ADDR;
                            quick <= 1'b0;
                        end else if (next_in[7:0] == CMD_QUICK) begin
                            state <= SD_ADDR;
                            quick <= 1'b1;
                        end else begin
                            state <= SD_IGNORE;
                        end
                    end
                end
                SD_ADDR: begin
                    if (cnt == ADDR_LAST) begin
                        cnt <= 5'h00;
                        state <= quick ? SD_DUMMY : SD_DATA;
                    end
                end
                SD_DUMMY: begin
                    if (cnt == DUMMY_LAST) begin
                        cnt <= 5'h00;
                        state <= SD_DATA;
                    end
                end
                SD_DATA, SD_IGNORE: begin
                    cnt <= 5'h00;  // Input no longer matters
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Data output shifter

    logic [2:0] bitpos;    // Bit of byte on the wire
    logic [7:0] out_sh;    // Remaining bits of byte
    logic [7:0] fetch;     // Prefetched next byte
    logic drive;           // First data bit presented
    logic load;            // Byte boundary on a fall
    logic miso;            // Output bit
    logic miso_oe;         // Output enable
    logic rd_d;            // Read answer due

    assign load = (state == SD_DATA) && sclk_fall && !paused && (bitpos == 3'h0);

    // Bits change only on a falling clock edge
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || sel_n) begin
            miso <= 1'b0;
            bitpos <= 3'h0;
            out_sh <= 8'h00;
            drive <= 1'b0;
        end else if (state != SD_DATA) begin
            bitpos <= 3'h0;
            drive <= 1'b0;
        end else if (sclk_fall && !paused) begin
            drive <= 1'b1;
            bitpos <= bitpos + 3'h1;
            if (bitpos == 3'h0) begin
                miso <= fetch[7];
                out_sh <= {fetch[6:0], 1'b0};
            end else begin
                miso <= out_sh[7];
                out_sh <= {out_sh[6:0], 1'b0};
            end
        end
    end

    // Enable follows the first data fall and drops on pause or deselect
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || sel_n) begin
            miso_oe <= 1'b0;
        end else begin
            miso_oe <= (state == SD_DATA) && !paused && (drive || sclk_fall);
        end
    end

    assign bus.miso = miso;
    assign bus.miso_oe = miso_oe;

    ////////////////////////////////////////////////////////////////
    // Memory fetch

    // One read at the end of address, one at each byte boundary
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mem_rd_o <= 1'b0;
            mem_addr_o <= '0;
        end else if (addr_done) begin
            mem_rd_o <= 1'b1;
            mem_addr_o <= start_addr;
        end else if (load) begin
            mem_rd_o <= 1'b1;
            mem_addr_o <= mem_addr_o + 1'b1;
        end else begin
            mem_rd_o <= 1'b0;
        end
    end

    // Answer is taken the cycle after the request
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_d <= 1'b0;
            fetch <= 8'h00;
        end else begin
            rd_d <= mem_rd_o;
            if (rd_d) begin
                fetch <= mem_data_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status

    // A fetch in flight keeps the port active after deselect
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            active_o <= 1'b0;
            paused_o <= 1'b0;
        end else begin
            active_o <= ~sel_n | mem_rd_o | rd_d;
            paused_o <= paused;
        end
    end

endmodule
`default_nettype wire

//--- rtl/srp_host.sv
// Host end: SPI master issuing read and quick fetch
`default_nettype none
module srp_host
    import srp_pkg::*;
#(
    parameter int HALF = SCLK_HALF_CYC,
    parameter int LEN_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Serial link
    srp_if.host bus,
    // Request
    input wire logic start_i,
    input wire logic fast_i,
    input wire logic cpol_i,
    input wire logic pause_i,
    input wire logic [23:0] addr_i,
    input wire logic [LEN_W-1:0] len_i,
    // Answer
    output logic busy_o,
    output logic [7:0] byte_o,
    output logic byte_valid_o,
    output logic done_o
);
    localparam int CNT_W = LEN_W + 4;

    ////////////////////////////////////////////////////////////////
    // Miso synchroniser

    logic m1;  // First stage, read by m2 only
    logic m2;  // Safe level

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            m1 <= 1'b0;
            m2 <= 1'b0;
        end else begin
            m1 <= bus.miso;
            m2 <= m1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Clock and frame sequencer

    srp_host_state_type state;  // Frame state
    logic [7:0] tmr;            // Half period timer
    logic sclk;                 // Driven clock
    logic sel_n;                // Driven select
    logic pause_n;              // Driven pause
    logic mosi;                 // Driven data
    logic cpol;                 // Clock idle level of frame
    logic [39:0] tx_sh;         // Header shifter
    logic [CNT_W-1:0] rises;    // Rising edges given
    logic [CNT_W-1:0] total;    // Rising edges in frame
    logic [CNT_W-1:0] hdr;      // Header length
    logic expire, finish, go_pause, do_rise;

    assign expire = (state == SH_RUN) && (tmr == 8'(HALF - 1));
    assign finish = expire && (rises == total) && (sclk == cpol);
    assign go_pause = expire && !finish && !sclk && pause_i && (rises != '0);
    assign do_rise = expire && !finish && !go_pause && !sclk;

    // Data moves on falls, so the slave takes it on rises
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= SH_IDLE;
            tmr <= 8'h00;
            sclk <= 1'b0;
            sel_n <= 1'b1;
            pause_n <= 1'b1;
            mosi <= 1'b0;
            cpol <= 1'b0;
            tx_sh <= 40'h0000000000;
            rises <= '0;
            total <= '0;
            hdr <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            unique case (state)
                SH_IDLE: begin
                    sclk <= cpol_i;
                    if (start_i) begin
                        sel_n <= 1'b0;
                        cpol <= cpol_i;
                        tx_sh <= {fast_i ? CMD_QUICK : CMD_READ, addr_i, 8'h00};
                        mosi <= fast_i ? CMD_QUICK[7] : CMD_READ[7];
                        hdr <= CNT_W'(fast_i ? HDR_QUICK_BITS : HDR_READ_BITS);
                        total <= CNT_W'(fast_i ? HDR_QUICK_BITS : HDR_READ_BITS) + {len_i, 3'b000};
                        rises <= '0;
                        tmr <= 8'h00;
                        busy_o <= 1'b1;
                        state <= SH_RUN;
                    end
                end
                SH_RUN: begin
                    tmr <= expire ? 8'h00 : tmr + 8'h01;
                    if (finish) begin
                        sel_n <= 1'b1;
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        state <= SH_IDLE;
                    end else if (go_pause) begin
                        pause_n <= 1'b0;
                        state <= SH_PAUSE;
                    end else if (do_rise) begin
                        sclk <= 1'b1;
                        rises <= rises + 1'b1;
                    end else if (expire) begin
                        sclk <= 1'b0;
                        if (rises != '0) begin
                            mosi <= tx_sh[38];
                            tx_sh <= {tx_sh[38:0], 1'b0};
                        end
                    end
                end
                SH_PAUSE: begin
                    // Select stays low throughout, so no reset
                    if (!pause_i) begin
                        pause_n <= 1'b1;
                        state <= SH_RUN;
                    end
                end
            endcase
        end
    end

    assign bus.sclk = sclk;
    assign bus.select_n = sel_n;
    assign bus.pause_n = pause_n;
    assign bus.mosi = mosi;

    ////////////////////////////////////////////////////////////////
    // Receive bytes

    logic [6:0] rx_sh;  // Partial byte
    logic [2:0] rx_cnt; // Bits gathered

    // Sampled on rise, a full half period after the slave's fall
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_sh <= 7'h00;
            rx_cnt <= 3'h0;
            byte_o <= 8'h00;
            byte_valid_o <= 1'b0;
        end else begin
            byte_valid_o <= 1'b0;
            if (state == SH_IDLE) begin
                rx_cnt <= 3'h0;
            end else if (do_rise && (rises >= hdr)) begin
                rx_sh <= {rx_sh[5:0], m2};
                rx_cnt <= rx_cnt + 3'h1;
                if (rx_cnt == 3'h7) begin
                    byte_o <= {rx_sh, m2};
                    byte_valid_o <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

//--- dv/srp_assertions.sv
// Checker for the serial link between host and ROM read port
`default_nettype none
module srp_assertions
    import srp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Link signals
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic select_n,
    input wire logic pause_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////
    logic sclk_q; // Clock one sample ago
    logic sel_q; // Select one sample ago
    logic [7:0] nrise; // Rises in frame, saturating
    logic [7:0] cmd; // Captured instruction
    logic rise; // Counted clock rise
    // Select must already be low: hides the mode 3 idle jump at frame start
    assign rise = sclk && !sclk_q && !select_n && !sel_q;
    // Edge detection delay line
    always_ff @(posedge clk_i) begin
        sclk_q <= rst_n_i ? sclk : 1'b0;
        sel_q <= rst_n_i ? select_n : 1'b1;
    end
    // Rise counter, cleared while deselected
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || select_n) begin
            nrise <= 8'h00;
        end else if (rise && nrise != 8'hff) begin
            nrise <= nrise + 8'h01;
        end
    end
    // First eight bits form the instruction
    always_ff @(posedge clk_i) begin
        if (rise && nrise < 8'h08) begin
            cmd <= {cmd[6:0], mosi};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_miso_hold;
        (sclk && miso_oe && !select_n) [*6] |-> $stable(miso);
    endproperty
    a_miso_hold: assert property (p_miso_hold) else $error("miso moved while clock high");
    property p_mosi_hold;
        rise |-> $stable(mosi) ##1 $stable(mosi);
    endproperty
    a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved at capture");
    property p_oe_after_hdr;
        $rose(miso_oe) |-> nrise >= 8'h20;
    endproperty
    a_oe_after_hdr: assert property (p_oe_after_hdr) else $error("drive before header");
    property p_read_first;
        rise && cmd == CMD_READ && nrise == 8'h20 && pause_n && $past(pause_n, 8) |-> miso_oe;
    endproperty
    a_read_first: assert property (p_read_first) else $error("read data not driven");
    property p_quick_dummy;
        rise && cmd == CMD_QUICK && nrise >= 8'h20 && nrise < 8'h28 |-> !miso_oe;
    endproperty
    a_quick_dummy: assert property (p_quick_dummy) else $error("driven in dummy byte");
    property p_quick_first;
        rise && cmd == CMD_QUICK && nrise == 8'h28 && pause_n && $past(pause_n, 8) |-> miso_oe;
    endproperty
    a_quick_first: assert property (p_quick_first) else $error("quick data not driven");
    property p_oe_desel;
        select_n [*8] |-> !miso_oe;
    endproperty
    a_oe_desel: assert property (p_oe_desel) else $error("driven while deselected");
    property p_oe_pause;
        (!select_n && !pause_n && !sclk) [*8] |-> !miso_oe;
    endproperty
    a_oe_pause: assert property (p_oe_pause) else $error("driven while paused");
    property p_sclk_idle;
        select_n && $past(select_n) |-> $stable(sclk);
    endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("clock moved outside frame");
    property p_pause_sel;
        $fell(pause_n) |-> !select_n;
    endproperty
    a_pause_sel: assert property (p_pause_sel) else $error("pause while deselected");
    // Main scenarios reached
    c_read: cover property (rise && cmd == CMD_READ && nrise == 8'h20);
    c_quick: cover property (rise && cmd == CMD_QUICK && nrise == 8'h28);
    c_pause: cover property (!pause_n && !select_n && !miso_oe);
endmodule
`default_nettype wire

//--- dv/srp_tb.sv
// Testbench: host and device back to back, plus a bench-driven second link
`default_nettype none
module srp_tb
    import srp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_n_i; // Clock and sync reset
    logic start_i, fast_i, cpol_i, pause_i; // Host request
    logic [23:0] addr_i;
    logic [15:0] len_i;
    logic byte_valid, done, busy, active, paused, paused2; // Observed outputs
    logic [7:0] byte_q;
    logic [22:0] mem_addr, mem_addr2; // Array addresses
    logic [39:0] hdr; // Header bits seen on link one
    logic sclk_q, sel_q, oe2, seen_pause; // Monitor state
    int failures, comparisons, cyc, nr;
    ////////////////////////////////////////////////////////////////////////
    // Array contents: high address bits fold in so wrap and A23 show
    function automatic logic [7:0] rom(input logic [22:0] a);
        return a[7:0] ^ {1'b0, a[22:16]};
    endfunction
    srp_if bus();
    srp_if bus2();
    srp_host u_srp_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus), .start_i(start_i), .fast_i(fast_i),
        .cpol_i(cpol_i), .pause_i(pause_i), .addr_i(addr_i), .len_i(len_i), .busy_o(busy), .byte_o(byte_q),
        .byte_valid_o(byte_valid), .done_o(done));
    srp_device u_srp_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus), .mem_rd_o(),
        .mem_addr_o(mem_addr), .mem_data_i(rom(mem_addr)), .active_o(active), .paused_o(paused));
    srp_device u_srp_device_2 (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus2), .mem_rd_o(),
        .mem_addr_o(mem_addr2), .mem_data_i(rom(mem_addr2)), .active_o(), .paused_o(paused2));
    srp_assertions u_srp_assertions (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk(bus.sclk), .mosi(bus.mosi),
        .miso(bus.miso), .miso_oe(bus.miso_oe), .select_n(bus.select_n), .pause_n(bus.pause_n));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // Monitor in the clock domain, so sclk edges never race select
    always @(posedge clk_i) begin
        sclk_q <= bus.sclk;
        sel_q <= bus.select_n;
        if (bus.sclk && !sclk_q && !bus.select_n && !sel_q) begin
            hdr <= (nr < 40) ? {hdr[38:0], bus.mosi} : hdr;
            nr <= nr + 1;
        end
        if (bus2.miso_oe === 1'b1) oe2 <= 1'b1;
        if (paused === 1'b1) seen_pause <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            conclude();
        end
    end
    task automatic conclude();
        if (failures == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // One host transfer; ps is the cycle to pause at, negative for none
    task automatic run(input logic fast, input logic cpol, input logic [23:0] a, input int n, input int ps);
        int k;
        int i;
        k = 0;
        nr = 0;
        seen_pause = 1'b0;
        start_i <= 1'b1;
        fast_i <= fast;
        cpol_i <= cpol;
        addr_i <= a;
        len_i <= 16'(n);
        @(posedge clk_i);
        start_i <= 1'b0;
        for (i = 0; i < 9000 && done !== 1'b1; i++) begin
            @(posedge clk_i);
            if (i == ps) pause_i <= 1'b1;
            if (i == ps + 60) pause_i <= 1'b0;
            if (byte_valid === 1'b1) begin
                check("byte", 32'(rom(23'(a[22:0] + k))), 32'(byte_q));
                k++;
            end
        end
        check("done", 32'h1, 32'(done === 1'b1));
        check("busy", 32'h0, 32'(busy));
        check("bytes", 32'(n), 32'(k));
        check("header", {fast ? CMD_QUICK : CMD_READ, a}, hdr[39:8]);
        check("rises", 32'((fast ? 40 : 32) + 8 * n), 32'(nr));
        if (ps >= 0) check("pause seen", 32'h1, 32'(seen_pause));
        repeat (12) @(posedge clk_i);
        check("idle clock", 32'(cpol), 32'(bus.sclk));
        check("standby", 32'h0, 32'(active));
    endtask
    // One byte on link two, mode 0, 32 ns serial period
    task automatic xfer(input logic [7:0] o, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            bus2.mosi <= o[i];
            repeat (4) @(posedge clk_i);
            bus2.sclk <= 1'b1;
            repeat (4) @(posedge clk_i);
            r[i] = bus2.miso_oe ? bus2.miso : ~bus2.miso; // Released line reads inverted
            bus2.sclk <= 1'b0;
        end
    endtask
    // Frame on link two; select is left low for the caller
    task automatic b_read(input logic [7:0] c, input logic [23:0] a, input int n, input logic chk);
        logic [7:0] r;
        bus2.select_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        xfer(c, r);
        xfer(a[23:16], r);
        xfer(a[15:8], r);
        xfer(a[7:0], r);
        if (c == CMD_QUICK) xfer(8'hff, r);
        for (int k = 0; k < n; k++) begin
            xfer(8'h00, r);
            if (chk) check("link byte", 32'(rom(23'(a[22:0] + k))), 32'(r));
        end
    endtask
    // Deselect; released data line is flipped so stale levels never help
    task automatic b_end();
        repeat (4) @(posedge clk_i);
        bus2.select_n <= 1'b1;
        bus2.mosi <= ~bus2.mosi;
        repeat (8) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        failures = 0;
        comparisons = 0;
        cyc = 0;
        nr = 0;
        {oe2, seen_pause, sclk_q, sel_q} = 4'h1;
        {rst_n_i, start_i, fast_i, cpol_i, pause_i, addr_i, len_i} = '0;
        {bus2.sclk, bus2.mosi, bus2.select_n, bus2.pause_n} = 4'h1;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // Link two held selected across reset: no falling edge yet
        b_read(CMD_READ, 24'h000040, 1, 1'b0);
        b_end();
        check("oe without select edge", 32'h0, 32'(oe2));
        run(1'b0, 1'b0, 24'h000010, 3, -1);
        run(1'b1, 1'b1, 24'hfffffe, 4, -1);
        run(1'b0, 1'b0, 24'h000100, 4, 600);
        oe2 = 1'b0;
        b_read(8'h5a, 24'h000000, 2, 1'b0);
        b_end();
        check("oe unknown code", 32'h0, 32'(oe2));
        b_read(CMD_READ, 24'h812345, 2, 1'b1);
        // Pause asked with the clock high must wait for the clock to fall
        repeat (4) @(posedge clk_i);
        bus2.sclk <= 1'b1;
        repeat (2) @(posedge clk_i);
        bus2.pause_n <= 1'b0;
        repeat (10) @(posedge clk_i);
        check("pause with clock high", 32'h0, 32'(paused2));
        bus2.sclk <= 1'b0;
        repeat (10) @(posedge clk_i);
        check("paused", 32'h1, 32'(paused2));
        check("oe paused", 32'h0, 32'(bus2.miso_oe));
        bus2.select_n <= 1'b1;
        repeat (10) @(posedge clk_i);
        check("pause cleared", 32'h0, 32'(paused2));
        bus2.pause_n <= 1'b1;
        repeat (4) @(posedge clk_i);
        b_read(CMD_QUICK, 24'h7ffffe, 3, 1'b1);
        b_end();
        conclude();
    end
endmodule
`default_nettype wire
